// File: dbsp_pkg.sv
package dbsp_pkg;
  // data path geometry
  localparam int DATA_W_DEF = 18;  // narrow variant word width
  localparam int ADDR_W_DEF = 20;  // narrow variant word address width
  localparam int ADDR_W_WIDE = 19; // wide (36-bit) variant address width
  localparam int LANE_W     = 9;   // bits gated by one lane select
  localparam int BANKS      = 4;   // equal storage arrays
  localparam int BANK_W     = 2;   // bits that pick an array
  localparam int BURST_LEN  = 4;   // words per transaction
  localparam int BEAT_W     = 2;   // width of beat and burst counters

  // beat counter reset value and last beat value
  localparam logic [BEAT_W-1:0] BEAT_RST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;

  // transaction sequencer, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01, // waiting for a load
    ST_WR    = 5'h02, // taking four write beats
    ST_RWAIT = 5'h04, // read loaded, waiting for first out edge
    ST_RD    = 5'h08, // driving read beats 1 to 3
    ST_DRAIN = 5'h10  // last beat stands until the next out edge
  } dbsp_state_t;

  // linear two-bit burst step, wraps inside the aligned group
  function automatic logic [BEAT_W-1:0] dbsp_step(
    input logic [BEAT_W-1:0] v
  );
    dbsp_step = v + 2'h1;
  endfunction
endpackage

// File: dbsp_array.sv
`timescale 1ns/1ps
module dbsp_array #(
  parameter int DATA_W = dbsp_pkg::DATA_W_DEF,
  parameter int ADDR_W = dbsp_pkg::ADDR_W_DEF
) (
  input  wire logic              clk,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [DATA_W/dbsp_pkg::LANE_W-1:0] wr_lane_n,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);
  import dbsp_pkg::*;

  localparam int LANES = DATA_W / LANE_W;        // lanes per word
  localparam int ROW_W = ADDR_W - BANK_W;        // row bits per array
  localparam int DEPTH = 1 << ROW_W;             // words per array

  // four equal arrays, picked by the low address bits
  logic [DATA_W-1:0] mem [BANKS][DEPTH];

  // masked lanes keep their old contents
  always_ff @(posedge clk) begin
    if (wr_en) begin
      for (int l = 0; l < LANES; l++) begin
        if (!wr_lane_n[l]) begin
          mem[wr_addr[BANK_W-1:0]][wr_addr[ADDR_W-1:BANK_W]]
            [l*LANE_W +: LANE_W] <= wr_data[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // combinational read so a beat can leave on any edge spacing
  assign rd_data = mem[rd_addr[BANK_W-1:0]][rd_addr[ADDR_W-1:BANK_W]];
endmodule

// File: dbsp_port.sv
`timescale 1ns/1ps
module dbsp_port #(
  parameter int DATA_W = dbsp_pkg::DATA_W_DEF,
  parameter int ADDR_W = dbsp_pkg::ADDR_W_DEF
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RESETN,
  input  wire logic              K,
  input  wire logic              K_N,
  input  wire logic              C,
  input  wire logic              C_N,
  input  wire logic              SINGLE_CLK,
  input  wire logic              LOAD_N,
  input  wire logic              READ_NOT_WRITE,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W/dbsp_pkg::LANE_W-1:0] BYTE_LANE_WRITE_N,
  input  wire logic [DATA_W-1:0] DQ_IN,
  output logic      [DATA_W-1:0] DQ_OUT,
  output logic                   DQ_OE,
  output logic                   BUSY
);
  import dbsp_pkg::*;

  // refuse shapes the lane and array logic cannot serve
  generate
    if (DATA_W % LANE_W != 0 || DATA_W < LANE_W) begin : g_bad_width
      $error("data width must be a whole number of nine-bit lanes");
    end
    if (DATA_W == DATA_W_DEF && ADDR_W != ADDR_W_DEF) begin : g_bad_nar
      $error("narrow variant needs a twenty-bit word address");
    end
    if (DATA_W == 2 * DATA_W_DEF && ADDR_W != ADDR_W_WIDE) begin : g_bad_wid
      $error("wide variant needs a nineteen-bit word address");
    end
    if (ADDR_W <= BANK_W) begin : g_bad_addr
      $error("address must be wider than the burst bits");
    end
  endgenerate

  localparam int HI_W = ADDR_W - BANK_W; // bits above the burst bits

  dbsp_state_t       state;        // sequencer state
  logic              k_q;          // last sampled true input clock
  logic              kn_q;         // last sampled complement input clock
  logic              c_q;          // last sampled true output clock
  logic              cn_q;         // last sampled complement output clock
  logic [HI_W-1:0]   base_hi;      // upper address of the burst
  logic [BEAT_W-1:0] burst_cnt;    // word position within the group
  logic [BEAT_W-1:0] beat;         // beats done in this burst
  logic              k_rise;       // true input clock rising
  logic              kn_rise;      // complement input clock rising
  logic              o_rise;       // true output edge in use
  logic              on_rise;      // complement output edge in use
  logic              wr_edge;      // edge expected for this write beat
  logic              rd_edge;      // edge expected for this read beat
  logic              load;         // command presented this edge
  logic              wr_en;        // a write beat lands now
  logic [ADDR_W-1:0] word_addr;    // address of the current beat
  logic [DATA_W-1:0] rd_word;      // word under the burst counter
  logic [BEAT_W-1:0] burst_start_bits; // low address bits of the load
  logic              rd_beat;      // a read beat issues at this edge

  // all clock pins are plain synchronous samples of the system clock
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      k_q  <= 1'b0;
      kn_q <= 1'b0;
      c_q  <= 1'b0;
      cn_q <= 1'b0;
    end else begin
      k_q  <= K;
      kn_q <= K_N;
      c_q  <= C;
      cn_q <= C_N;
    end
  end

  // edge detection against the previous sample
  assign k_rise  = K & ~k_q;
  assign kn_rise = K_N & ~kn_q;
  // single clock mode moves reads onto the input clocks
  assign o_rise  = SINGLE_CLK ? k_rise  : (C & ~c_q);
  assign on_rise = SINGLE_CLK ? kn_rise : (C_N & ~cn_q);

  // even beats sit on true edges, odd beats on complement edges
  assign wr_edge = beat[0] ? kn_rise : k_rise;
  assign rd_edge = beat[0] ? on_rise : o_rise;
  // the wait state issues beat 0, so it must step the counters as well,
  // otherwise the first word would be sent twice
  assign rd_beat = (state == ST_RWAIT || state == ST_RD) && rd_edge;

  // a load counts only on a true input clock rise while idle
  assign load = (state == ST_IDLE) && k_rise && !LOAD_N;

  assign burst_start_bits = ADDR[BANK_W-1:0];
  assign word_addr = {base_hi, burst_cnt};
  assign wr_en     = (state == ST_WR) && wr_edge;
  assign BUSY      = (state != ST_IDLE);

  // storage with per-lane write gating
  dbsp_array #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W)
  ) u_array (
    .clk       (CLK_SYS),
    .wr_en     (wr_en),
    .wr_addr   (word_addr),
    .wr_data   (DQ_IN),
    .wr_lane_n (BYTE_LANE_WRITE_N),
    .rd_addr   (word_addr),
    .rd_data   (rd_word)
  );

  // sequencer: one burst at a time, four beats each
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // direction high reads, low writes
          if (load) begin
            state <= READ_NOT_WRITE ? ST_RWAIT : ST_WR;
          end
        end
        ST_WR: begin
          if (wr_edge && beat == BEAT_LAST) begin
            state <= ST_IDLE;
          end
        end
        ST_RWAIT: begin
          // first read beat waits for a true output edge
          if (o_rise) begin
            state <= ST_RD;
          end
        end
        ST_RD: begin
          if (rd_edge && beat == BEAT_LAST) begin
            state <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          // last word stands for a full half period
          if (o_rise) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // address capture and burst counter
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      base_hi   <= '0;
      burst_cnt <= BEAT_RST;
    end else if (load) begin
      base_hi   <= ADDR[ADDR_W-1:BANK_W];
      burst_cnt <= burst_start_bits;
    end else if (wr_en || rd_beat) begin
      // linear step, wraps inside the aligned group of four
      burst_cnt <= dbsp_step(burst_cnt);
    end
  end

  // beat counter; the first read beat is issued from the wait state
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      beat <= BEAT_RST;
    end else if (load) begin
      beat <= BEAT_RST;
    end else if (wr_en || rd_beat) begin
      beat <= dbsp_step(beat);
    end
  end

  // read data register and driver enable
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      DQ_OUT <= '0;
      DQ_OE  <= 1'b0;
    end else begin
      unique case (state)
        ST_RWAIT, ST_RD: begin
          // rwait only moves on o_rise, which is its beat edge
          if ((state == ST_RWAIT && o_rise) ||
              (state == ST_RD && rd_edge)) begin
            DQ_OUT <= rd_word;
            DQ_OE  <= 1'b1;
          end
        end
        ST_DRAIN: begin
          if (o_rise) begin
            DQ_OE <= 1'b0;
          end
        end
        default: begin
          // nothing selected for read: drivers stay off
          DQ_OE <= 1'b0;
        end
      endcase
    end
  end
endmodule

// File: dbsp_port_asserts.sv
`timescale 1ns/1ps
// pin rises rebuilt from one cycle of history, cleared in reset
module dbsp_port_chk #(
  parameter int DATA_W = 18
) (
  input wire logic              CLK_SYS,
  input wire logic              RESETN,
  input wire logic              K,
  input wire logic              K_N,
  input wire logic              C,
  input wire logic              C_N,
  input wire logic              SINGLE_CLK,
  input wire logic              LOAD_N,
  input wire logic              READ_NOT_WRITE,
  input wire logic [DATA_W-1:0] DQ_OUT,
  input wire logic              DQ_OE,
  input wire logic              BUSY
);
  logic kq, knq, cq, cnq;     // pin levels one cycle back
  logic kr, knr, orr, onr;    // rises seen this cycle
  logic ld;                   // command accepted this cycle
  // history
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) {kq, knq, cq, cnq} <= 4'h0;
    else {kq, knq, cq, cnq} <= {K, K_N, C, C_N};
  end
  assign kr  = K & ~kq;
  assign knr = K_N & ~knq;
  assign orr = SINGLE_CLK ? kr : C & ~cq;      // read clock, true side
  assign onr = SINGLE_CLK ? knr : C_N & ~cnq;  // read clock, complement
  assign ld  = kr & ~LOAD_N & ~BUSY;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  AST_LOAD_BUSY: assert property (ld |=> BUSY)
    else $error("accepted load did not start a burst");
  AST_IDLE_HIZ: assert property (!BUSY |-> !DQ_OE)
    else $error("data driven while idle");
  AST_WR_HIZ: assert property (ld && !READ_NOT_WRITE |=> !DQ_OE [*8])
    else $error("data driven during a write");
  AST_WR_HOLD: assert property (ld && !READ_NOT_WRITE |=> BUSY [*4])
    else $error("write burst ended too soon");
  AST_BUSY_END: assert property (
    $fell(BUSY) |-> $past(knr) || $past(orr))
    else $error("burst ended off a beat edge");
  AST_RD_FIRST: assert property ($rose(DQ_OE) |-> $past(orr))
    else $error("first read beat not on true output rise");
  AST_RD_STEP: assert property (
    DQ_OE && $past(DQ_OE) && !$stable(DQ_OUT) |-> $past(orr) || $past(onr))
    else $error("read data changed off an output edge");
  AST_RD_OE: assert property (ld && READ_NOT_WRITE |-> ##[1:40] DQ_OE)
    else $error("read never drove data");
  AST_OE_FALL: assert property ($fell(DQ_OE) |-> $fell(BUSY))
    else $error("drivers released apart from burst end");
endmodule
bind dbsp_port dbsp_port_chk #(.DATA_W(DATA_W)) i_chk (.CLK_SYS, .RESETN,
  .K, .K_N, .C, .C_N, .SINGLE_CLK, .LOAD_N, .READ_NOT_WRITE, .DQ_OUT,
  .DQ_OE, .BUSY);

// File: dbsp_ctrl_model.sv
`timescale 1ns/1ps
// controller side: free-running clocks, one burst at a time
module dbsp_ctrl_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        go,      // start a burst when idle
  input  wire logic        rnw,
  input  wire logic        single,
  input  wire logic [19:0] addr,
  input  wire logic [71:0] wd,      // beat 0 in the low bits
  input  wire logic [7:0]  wl,
  input  wire logic [17:0] dq_out,
  input  wire logic        dq_oe,
  output logic             k,
  output logic             k_n,
  output logic             c,
  output logic             c_n,
  output logic             load_n,
  output logic             rd_nw,
  output logic      [19:0] a,
  output logic      [1:0]  lane_n,
  output logic      [17:0] dq,
  output logic             act,
  output logic      [71:0] rdat
);
  logic [1:0] ph;   // clock phase, K high in 0 and 1
  logic [4:0] t;    // cycles since the load cycle
  logic [4:0] b;    // first capture cycle of a read
  assign k   = ~ph[1];
  assign k_n = ph[1];
  assign c   = ph[1] ^ ph[0];  // output clock a quarter behind
  assign c_n = ~c;
  assign b   = single ? 5'h5 : 5'h2;
  // K starts low so release is no rise
  always_ff @(posedge clk) begin
    if (!rst_n) ph <= 2'h2;
    else ph <= ph + 2'h1;
  end
  // command: load only where the next cycle is a K rise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      act <= 1'b0;
      load_n <= 1'b1;
    end else if (!act && go && ph == 2'h3) begin
      act <= 1'b1;
      load_n <= 1'b0;
      rd_nw <= rnw;
      a <= addr;
      t <= 5'h0;
    end else begin
      load_n <= 1'b1;
      a <= ~a;         // address no longer held
      t <= t + 5'h1;
      if (t == 5'h0C) act <= 1'b0;
    end
  end
  // write beats sit in the cycle of their rise, stale data inverted
  always_ff @(posedge clk) begin
    if (!rst_n) {dq, lane_n} <= '0;
    else if (act && !rd_nw && t[0] && t >= 5'h3 && t <= 5'h9) begin
      dq <= wd[18*((t-5'h3)>>1) +: 18];
      lane_n <= wl[2*((t-5'h3)>>1) +: 2];
    end else {dq, lane_n} <= ~{dq, lane_n};
  end
  // read words taken one cycle after their issuing edge
  always_ff @(posedge clk) begin
    if (act && rd_nw && t >= b && t <= b + 5'h6 && !(t[0] ^ b[0]))
      rdat[18*((t-b)>>1) +: 18] <= dq_oe ? dq_out : 18'hX;
  end
endmodule

// File: ddr_burst4_sram_data_port_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
  failures++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module ddr_burst4_sram_data_port_bench;
  import dbsp_pkg::*;
  logic clk, rst_n, go, rnw, single, k, k_n, c, c_n, load_n, rd_nw;
  logic dq_oe, act, busy;
  logic [19:0] addr, a;
  logic [71:0] wd, rdat;
  logic [7:0]  wl;
  logic [1:0]  lane_n;
  logic [17:0] dq, dq_out;
  logic [31:0] lfsr = 32'hC75AF6EA;
  logic [17:0] mem [16];  // expected contents, {group, offset}
  logic [17:0] grp [4] = '{18'h00000, 18'h3FFFF, 18'h2AAAA, 18'h15555};
  int failures = 0, n_compared = 0;
  dbsp_port #(.DATA_W(18), .ADDR_W(20)) i_dut (.CLK_SYS(clk),
    .RESETN(rst_n), .K(k), .K_N(k_n), .C(c), .C_N(c_n),
    .SINGLE_CLK(single), .LOAD_N(load_n), .READ_NOT_WRITE(rd_nw),
    .ADDR(a), .BYTE_LANE_WRITE_N(lane_n), .DQ_IN(dq), .DQ_OUT(dq_out),
    .DQ_OE(dq_oe), .BUSY(busy));
  dbsp_ctrl_model i_ctrl (.clk(clk), .rst_n(rst_n), .go(go), .rnw(rnw),
    .single(single), .addr(addr), .wd(wd), .wl(wl), .dq_out(dq_out),
    .dq_oe(dq_oe), .k(k), .k_n(k_n), .c(c), .c_n(c_n), .load_n(load_n),
    .rd_nw(rd_nw), .a(a), .lane_n(lane_n), .dq(dq), .act(act),
    .rdat(rdat));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // unselected lanes keep the old byte
  function automatic logic [17:0] merge(input logic [17:0] o, n,
                                        input logic [1:0] ln);
    merge = o;
    for (int i = 0; i < 2; i++)
      if (!ln[i]) merge[LANE_W*i +: LANE_W] = n[LANE_W*i +: LANE_W];
  endfunction
  task automatic final_report();
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic roll();
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      wd[24*i +: 24] <= lfsr[23:0];
    end
    lfsr = nxt(lfsr);
    wl <= lfsr[7:0];
  endtask
  // one burst; offsets wrap inside the aligned group
  task automatic burst(input logic rw, input logic [1:0] g, o);
    int n;
    logic [3:0] ix;
    go <= 1'b1;
    rnw <= rw;
    addr <= {grp[g], o};
    // a wait that runs out is a mismatch
    for (n = 0; !act; n++) begin
      if (n > 40) begin
        failures++;
        final_report();
      end else @(posedge clk);
    end
    go <= 1'b0;
    for (n = 0; act; n++) begin
      if (n > 40) begin
        failures++;
        final_report();
      end else @(posedge clk);
    end
    `CHK("busy after burst", 1'b0, busy)
    `CHK("drivers off after burst", 1'b0, dq_oe)
    for (int i = 0; i < 4; i++) begin
      ix = {g, o + i[1:0]};
      if (!rw) mem[ix] = merge(mem[ix], wd[18*i +: 18], wl[2*i +: 2]);
      else `CHK("read word", mem[ix], rdat[18*i +: 18])
    end
  endtask
  initial begin
    {rst_n, go, rnw, single, addr, wd, wl} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int g = 0; g < 4; g++) begin  // whole groups first, all lanes
      roll();
      wl <= 8'h00;
      burst(1'b0, g[1:0], 2'h0);
    end
    for (int j = 0; j < 80; j++) begin  // mixed traffic, both read modes
      roll();
      lfsr = nxt(lfsr);
      single <= lfsr[9];
      burst(lfsr[8], lfsr[1:0], lfsr[3:2]);
    end
    final_report();
  end
endmodule
